// ### design/ldcfg_irq_route.sv
`timescale 1ns/100ps
`default_nettype none
module ldcfg_irq_route
	import ldcfg_pkg::*;
(
	// Clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  rst,
	// Configuration
	input  wire logic                  active,
	input  wire logic [3:0]            level_select,
	input  wire logic                  polarity_invert,
	input  wire logic                  wake_enable,
	// Device interrupt request
	input  wire logic                  dev_irq,
	// Results
	output logic [ldcfg_pkg::IRQ_LEVELS-1:0] serirq_levels,
	output logic                       wake_event,
	output logic                       route_invalid
);
	import ldcfg_pkg::*;

	logic        req_pol;
	logic        level_ok;
	logic [IRQ_LEVELS-1:0] lvl_d;

	assign req_pol  = dev_irq ^ polarity_invert;
	assign level_ok = (level_select != IRQ_NONE) &&
		((level_select <= IRQ_LAST_LOW) || (level_select >= IRQ_FIRST_HIGH));

	genvar g;
	generate
		for (g = 0; g < IRQ_LEVELS; g = g + 1) begin : g_lvl
			assign lvl_d[g] = active && level_ok && (level_select == 4'(g)) && req_pol;
		end
	endgenerate

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			serirq_levels <= '0;
			wake_event    <= 1'b0;
			route_invalid <= 1'b0;
		end else begin
			serirq_levels <= lvl_d;
			wake_event    <= active && wake_enable && dev_irq;
			route_invalid <= !level_ok && (level_select != IRQ_NONE);
		end
	end

	a_wake_gate: assert property (@(posedge sys_clk) disable iff (rst)
		!wake_enable |=> !wake_event) else $error("wake event without enable");
	a_invalid_level: assert property (@(posedge sys_clk) disable iff (rst)
		(level_select == 4'hd) |=> (serirq_levels == '0)) else $error("level 13 driven");
endmodule : ldcfg_irq_route
`default_nettype wire

// ### design/ldcfg_pkg.sv
package ldcfg_pkg;
	// Index space of the configuration pair
	localparam logic [7:0] IDX_DEVICE_SELECTOR = 8'h07;
	localparam logic [7:0] IDX_ACTIVATE        = 8'h30;
	localparam logic [7:0] IDX_BASE0_HIGH      = 8'h60;
	localparam logic [7:0] IDX_BASE0_LOW       = 8'h61;
	localparam logic [7:0] IDX_BASE1_HIGH      = 8'h62;
	localparam logic [7:0] IDX_BASE1_LOW       = 8'h63;
	localparam logic [7:0] IDX_IRQ_NUMBER      = 8'h70;
	localparam logic [7:0] IDX_IRQ_TYPE        = 8'h71;
	localparam logic [7:0] IDX_DMA_ZERO        = 8'h74;
	localparam logic [7:0] IDX_DMA_ONE         = 8'h75;
	localparam logic [7:0] IDX_GATED_LOW       = 8'h60;
	localparam logic [7:0] IDX_GATED_HIGH      = 8'hfe;
	// Logical device number of the wake-up controller
	localparam logic [7:0] LDN_WAKE_CTRL       = 8'h04;
	// Field positions
	localparam int ACTIVE_BIT      = 0;
	localparam int WAKE_EN_BIT     = 4;
	localparam int POLARITY_BIT    = 1;
	localparam int TRIG_SCRATCH_BIT = 0;
	// Write masks: bits that hold state
	localparam logic [7:0] MASK_ACTIVATE  = 8'h01;
	localparam logic [7:0] MASK_BASE0_LOW = 8'he0;
	localparam logic [7:0] MASK_IRQ_NUM   = 8'h1f;
	localparam logic [7:0] MASK_IRQ_TYPE  = 8'h03;
	// Reset values
	localparam logic [7:0] RST_ACTIVATE   = 8'h00;
	localparam logic [7:0] RST_BASE0_HIGH = 8'h00;
	localparam logic [7:0] RST_BASE0_LOW  = 8'h00;
	localparam logic [7:0] RST_IRQ_NUM    = 8'h00;
	localparam logic [7:0] RST_IRQ_TYPE   = 8'h03;
	localparam logic [7:0] DMA_NONE_VALUE = 8'h04;
	localparam logic [7:0] READ_ZERO      = 8'h00;
	localparam logic [3:0] IRQ_NONE       = 4'h0;
	localparam logic [3:0] IRQ_LAST_LOW   = 4'hc;
	localparam logic [3:0] IRQ_FIRST_HIGH = 4'he;
	// Number of serial IRQ level outputs (0..15); levels 0 and 13 are never driven
	localparam int IRQ_LEVELS = 16;
endpackage : ldcfg_pkg

// ### design/ldcfg_regs.sv
`timescale 1ns/100ps
`default_nettype none
module ldcfg_regs
	import ldcfg_pkg::*;
(
	// Clock and reset
	input  wire logic                        sys_clk,
	input  wire logic                        rst,
	// Index-data configuration access, device number decoded here against LDN_WAKE_CTRL
	input  wire logic [7:0]                  cfg_index,
	input  wire logic [7:0]                  cfg_wdata,
	input  wire logic                        cfg_wr,
	input  wire logic                        cfg_rd,
	input  wire logic [7:0]                  cfg_ldn,
	output logic [7:0]                       cfg_rdata,
	// Interrupt source of this device
	input  wire logic                        dev_irq,
	// Decoded configuration
	output logic                             dev_active,
	output logic [15:0]                      io_window_base,
	output logic [ldcfg_pkg::IRQ_LEVELS-1:0] serirq_levels,
	output logic                             wake_event,
	output logic                             route_invalid
);
	import ldcfg_pkg::*;

	// ==========================================================
	// Register state
	logic [7:0] activate_q;
	logic [7:0] activate_d;
	logic [7:0] base0_hi_q;
	logic [7:0] base0_hi_d;
	logic [7:0] base0_lo_q;
	logic [7:0] base0_lo_d;
	logic [7:0] irq_num_q;
	logic [7:0] irq_num_d;
	logic [7:0] irq_type_q;
	logic [7:0] irq_type_d;
	logic [7:0] rdata_d;

	// ==========================================================
	// Decode
	logic sel;
	logic gated_idx;
	logic open_idx;
	logic wr_act, wr_b0h, wr_b0l, wr_num, wr_type;

	assign sel       = (cfg_ldn == LDN_WAKE_CTRL);
	// Upper registers vanish while the device is inactive
	assign gated_idx = (cfg_index >= IDX_GATED_LOW) && (cfg_index <= IDX_GATED_HIGH);
	assign open_idx  = !gated_idx || activate_q[ACTIVE_BIT];
	assign wr_act    = sel && cfg_wr && (cfg_index == IDX_ACTIVATE);
	assign wr_b0h    = sel && cfg_wr && open_idx && (cfg_index == IDX_BASE0_HIGH);
	assign wr_b0l    = sel && cfg_wr && open_idx && (cfg_index == IDX_BASE0_LOW);
	assign wr_num    = sel && cfg_wr && open_idx && (cfg_index == IDX_IRQ_NUMBER);
	assign wr_type   = sel && cfg_wr && open_idx && (cfg_index == IDX_IRQ_TYPE);
	// Second descriptor and DMA indices have no write path at all

	assign activate_d = wr_act  ? (cfg_wdata & MASK_ACTIVATE)  : activate_q;
	assign base0_hi_d = wr_b0h  ? cfg_wdata                    : base0_hi_q;
	assign base0_lo_d = wr_b0l  ? (cfg_wdata & MASK_BASE0_LOW) : base0_lo_q;
	assign irq_num_d  = wr_num  ? (cfg_wdata & MASK_IRQ_NUM)   : irq_num_q;
	assign irq_type_d = wr_type ? (cfg_wdata & MASK_IRQ_TYPE)  : irq_type_q;

	// ==========================================================
	// Read mux
	always_comb begin
		rdata_d = READ_ZERO;
		if (sel && cfg_rd && open_idx) begin
			unique case (cfg_index)
				IDX_ACTIVATE:   rdata_d = activate_q;
				IDX_BASE0_HIGH: rdata_d = base0_hi_q;
				IDX_BASE0_LOW:  rdata_d = base0_lo_q;
				IDX_BASE1_HIGH: rdata_d = READ_ZERO;
				IDX_BASE1_LOW:  rdata_d = READ_ZERO;
				IDX_IRQ_NUMBER: rdata_d = irq_num_q;
				IDX_IRQ_TYPE:   rdata_d = irq_type_q;
				IDX_DMA_ZERO:   rdata_d = DMA_NONE_VALUE;
				IDX_DMA_ONE:    rdata_d = DMA_NONE_VALUE;
				default:        rdata_d = READ_ZERO;
			endcase
		end
	end

	// ==========================================================
	// Flops
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			activate_q <= RST_ACTIVATE;
			base0_hi_q <= RST_BASE0_HIGH;
			base0_lo_q <= RST_BASE0_LOW;
			irq_num_q  <= RST_IRQ_NUM;
			irq_type_q <= RST_IRQ_TYPE;
			cfg_rdata  <= READ_ZERO;
		end else begin
			activate_q <= activate_d;
			base0_hi_q <= base0_hi_d;
			base0_lo_q <= base0_lo_d;
			irq_num_q  <= irq_num_d;
			irq_type_q <= irq_type_d;
			cfg_rdata  <= rdata_d;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			dev_active     <= 1'b0;
			io_window_base <= 16'h0000;
		end else begin
			dev_active     <= activate_q[ACTIVE_BIT];
			io_window_base <= {base0_hi_q, base0_lo_q};
		end
	end

	// ==========================================================
	// Interrupt routing; trigger scratch bit deliberately not passed
	ldcfg_irq_route u_route (
		.sys_clk         (sys_clk),
		.rst             (rst),
		.active          (activate_q[ACTIVE_BIT]),
		.level_select    (irq_num_q[3:0]),
		.polarity_invert (irq_type_q[POLARITY_BIT]),
		.wake_enable     (irq_num_q[WAKE_EN_BIT]),
		.dev_irq         (dev_irq),
		.serirq_levels   (serirq_levels),
		.wake_event      (wake_event),
		.route_invalid   (route_invalid)
	);

	// ==========================================================
	// Checks
	a_align_low: assert property (@(posedge sys_clk) disable iff (rst)
		base0_lo_q[4:0] == 5'h00)
		else $error("base low bits not zero");

	a_dma_none: assert property (@(posedge sys_clk) disable iff (rst)
		(sel && cfg_rd && activate_q[ACTIVE_BIT] && cfg_index == IDX_DMA_ZERO)
		|=> (cfg_rdata == DMA_NONE_VALUE)) else $error("dma select not four");

	a_base1_zero: assert property (@(posedge sys_clk) disable iff (rst)
		(cfg_rd && cfg_index == IDX_BASE1_LOW) |=> (cfg_rdata == READ_ZERO))
		else $error("second base nonzero");

	a_inactive_lock: assert property (@(posedge sys_clk) disable iff (rst)
		(!activate_q[ACTIVE_BIT] && cfg_wr && cfg_index == IDX_IRQ_NUMBER)
		|=> $stable(irq_num_q)) else $error("write while inactive");

	a_unsel_lock: assert property (@(posedge sys_clk) disable iff (rst)
		(!sel && cfg_wr) |=> $stable(activate_q))
		else $error("write to unselected");

	a_type_write: assert property (@(posedge sys_clk) disable iff (rst)
		wr_type |=> (irq_type_q == ($past(cfg_wdata) & MASK_IRQ_TYPE)))
		else $error("type write lost");

	a_reserved_num: assert property (@(posedge sys_clk) disable iff (rst)
		irq_num_q[7:5] == 3'b000)
		else $error("reserved bits set");

	a_act_reserved: assert property (@(posedge sys_clk) disable iff (rst)
		activate_q[7:1] == 7'h00)
		else $error("activate reserved set");

	a_polarity_route: assert property (@(posedge sys_clk) disable iff (rst)
		(activate_q[ACTIVE_BIT] && irq_num_q[3:0] == 4'h3 && $stable(irq_type_q)
		&& $stable(irq_num_q) && $stable(activate_q) && irq_type_q[POLARITY_BIT] && !dev_irq)
		|=> serirq_levels[3]) else $error("inverted request not driven");

	// ==========================================================
	// Write acceptance and hold
	a_act_write: assert property (@(posedge sys_clk) disable iff (rst)
		wr_act |=> (activate_q == ($past(cfg_wdata) & MASK_ACTIVATE)))
		else $error("activate write lost");

	a_act_hold: assert property (@(posedge sys_clk) disable iff (rst)
		!wr_act |=> $stable(activate_q))
		else $error("activate changed without write");

	a_b0h_write: assert property (@(posedge sys_clk) disable iff (rst)
		wr_b0h |=> (base0_hi_q == $past(cfg_wdata)))
		else $error("base high write lost");

	a_b0h_hold: assert property (@(posedge sys_clk) disable iff (rst)
		!wr_b0h |=> $stable(base0_hi_q))
		else $error("base high changed without write");

	a_b0l_write: assert property (@(posedge sys_clk) disable iff (rst)
		wr_b0l |=> (base0_lo_q == ($past(cfg_wdata) & MASK_BASE0_LOW)))
		else $error("base low write lost");

	a_b0l_hold: assert property (@(posedge sys_clk) disable iff (rst)
		!wr_b0l |=> $stable(base0_lo_q))
		else $error("base low changed without write");

	a_num_write: assert property (@(posedge sys_clk) disable iff (rst)
		wr_num |=> (irq_num_q == ($past(cfg_wdata) & MASK_IRQ_NUM)))
		else $error("irq number write lost");

	a_num_hold: assert property (@(posedge sys_clk) disable iff (rst)
		!wr_num |=> $stable(irq_num_q))
		else $error("irq number changed without write");

	a_type_hold: assert property (@(posedge sys_clk) disable iff (rst)
		!wr_type |=> $stable(irq_type_q))
		else $error("irq type changed without write");

	a_type_reserved: assert property (@(posedge sys_clk) disable iff (rst)
		irq_type_q[7:2] == 6'h00)
		else $error("irq type reserved set");

	a_unsel_num: assert property (@(posedge sys_clk) disable iff (rst)
		(!sel && cfg_wr) |=> $stable(irq_num_q))
		else $error("irq number written while unselected");

	// ==========================================================
	// Read path
	a_rdata_idle: assert property (@(posedge sys_clk) disable iff (rst)
		!cfg_rd |=> (cfg_rdata == READ_ZERO))
		else $error("read data without read");

	a_rdata_unsel: assert property (@(posedge sys_clk) disable iff (rst)
		(!sel && cfg_rd) |=> (cfg_rdata == READ_ZERO))
		else $error("unselected device answered");

	a_rdata_closed: assert property (@(posedge sys_clk) disable iff (rst)
		(cfg_rd && gated_idx && !activate_q[ACTIVE_BIT]) |=> (cfg_rdata == READ_ZERO))
		else $error("inactive device answered");

	a_dma_one: assert property (@(posedge sys_clk) disable iff (rst)
		(sel && cfg_rd && open_idx && cfg_index == IDX_DMA_ONE)
		|=> (cfg_rdata == DMA_NONE_VALUE)) else $error("second dma select not four");

	a_base1_high: assert property (@(posedge sys_clk) disable iff (rst)
		(cfg_rd && cfg_index == IDX_BASE1_HIGH) |=> (cfg_rdata == READ_ZERO))
		else $error("second base high nonzero");

	a_read_act: assert property (@(posedge sys_clk) disable iff (rst)
		(sel && cfg_rd && cfg_index == IDX_ACTIVATE) |=> (cfg_rdata == $past(activate_q)))
		else $error("activate read wrong");

	a_read_num: assert property (@(posedge sys_clk) disable iff (rst)
		(sel && cfg_rd && open_idx && cfg_index == IDX_IRQ_NUMBER)
		|=> (cfg_rdata == $past(irq_num_q))) else $error("irq number read wrong");

	a_read_type: assert property (@(posedge sys_clk) disable iff (rst)
		(sel && cfg_rd && open_idx && cfg_index == IDX_IRQ_TYPE)
		|=> (cfg_rdata == $past(irq_type_q))) else $error("irq type read wrong");

	a_read_b0h: assert property (@(posedge sys_clk) disable iff (rst)
		(sel && cfg_rd && open_idx && cfg_index == IDX_BASE0_HIGH)
		|=> (cfg_rdata == $past(base0_hi_q))) else $error("base high read wrong");

	a_read_b0l: assert property (@(posedge sys_clk) disable iff (rst)
		(sel && cfg_rd && open_idx && cfg_index == IDX_BASE0_LOW)
		|=> (cfg_rdata == $past(base0_lo_q))) else $error("base low read wrong");

	a_unused_idx: assert property (@(posedge sys_clk) disable iff (rst)
		(cfg_rd && cfg_index > IDX_DMA_ONE) |=> (cfg_rdata == READ_ZERO))
		else $error("unused index nonzero");

	// ==========================================================
	// Decoded outputs
	a_active_copy: assert property (@(posedge sys_clk) disable iff (rst)
		1'b1 |=> (dev_active == $past(activate_q[ACTIVE_BIT])))
		else $error("active output stale");

	a_window_copy: assert property (@(posedge sys_clk) disable iff (rst)
		1'b1 |=> (io_window_base == {$past(base0_hi_q), $past(base0_lo_q)}))
		else $error("window base stale");

	a_window_align: assert property (@(posedge sys_clk) disable iff (rst)
		io_window_base[4:0] == 5'h00)
		else $error("window base not aligned");

	a_levels_inactive: assert property (@(posedge sys_clk) disable iff (rst)
		!activate_q[ACTIVE_BIT] |=> (serirq_levels == '0))
		else $error("inactive device drives irq");

	a_wake_inactive: assert property (@(posedge sys_clk) disable iff (rst)
		!activate_q[ACTIVE_BIT] |=> !wake_event)
		else $error("inactive device wakes");

	a_levels_onehot: assert property (@(posedge sys_clk) disable iff (rst)
		$onehot0(serirq_levels))
		else $error("several irq levels driven");

	a_level_none: assert property (@(posedge sys_clk) disable iff (rst)
		(irq_num_q[3:0] == IRQ_NONE) |=> (serirq_levels == '0))
		else $error("irq driven with level zero");

	a_invalid_flag: assert property (@(posedge sys_clk) disable iff (rst)
		(irq_num_q[3:0] == 4'hd) |=> route_invalid)
		else $error("level 13 not flagged");
endmodule : ldcfg_regs
`default_nettype wire

// ### verification/ldcfg_host.sv
`timescale 1ns/100ps
`default_nettype none
module ldcfg_host (
	// Clock
	input  wire logic       sys_clk,
	// Configuration access
	output logic [7:0]      cfg_index,
	output logic [7:0]      cfg_wdata,
	output logic            cfg_wr,
	output logic            cfg_rd,
	output logic [7:0]      cfg_ldn,
	input  wire logic [7:0] cfg_rdata
);
	initial begin
		{cfg_index, cfg_wdata, cfg_wr, cfg_rd, cfg_ldn} = '0;
	end
	// ==========================================
	// One access; a free cycle always follows
	task automatic access(input logic [7:0] device_selector, input logic [7:0] idx,
		input logic [7:0] d, input logic wr, output logic [7:0] rd);
		@(negedge sys_clk);
		cfg_ldn   = device_selector;
		cfg_index = idx;
		cfg_wdata = d;
		cfg_wr    = wr;
		cfg_rd    = !wr;
		@(negedge sys_clk);
		rd = cfg_rdata;
		cfg_wr = 1'b0;
		cfg_rd = 1'b0;
	endtask : access
endmodule : ldcfg_host
`default_nettype wire

// ### verification/tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b, m) begin comparisons++; if ((a) !== (b)) begin err_total++; \
	$display("CHECK FAILED %0t %s", $time, m); end end
module tb;
	import ldcfg_pkg::*;
	logic sys_clk = 1'b0, rst = 1'b1, dev_irq = 1'b0, cfg_wr, cfg_rd, dev_active;
	logic wake_event, route_invalid;
	logic [7:0] cfg_index, cfg_wdata, cfg_ldn, cfg_rdata, rd;
	logic [15:0] io_window_base;
	logic [IRQ_LEVELS-1:0] serirq_levels;
	int err_total, comparisons, cycles, act, b0h, b0l, irqn, irqt;
	int idxs[$] = '{'h30, 'h60, 'h61, 'h62, 'h63, 'h70, 'h71, 'h74, 'h75, 'h80};
	int dir_i[8] = '{'h30, 'h61, 'h70, 'h70, 'h71, 'h71, 'h62, 'h74};
	int dir_d[8] = '{'h01, 'hff, 'h0d, 'h13, 'h02, 'h01, 'h55, 'h55};
	always #5 sys_clk = ~sys_clk;
	ldcfg_regs i_ldcfg_regs (.sys_clk(sys_clk), .rst(rst), .cfg_index(cfg_index),
		.cfg_wdata(cfg_wdata), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_ldn(cfg_ldn),
		.cfg_rdata(cfg_rdata), .dev_irq(dev_irq), .dev_active(dev_active),
		.io_window_base(io_window_base), .serirq_levels(serirq_levels),
		.wake_event(wake_event), .route_invalid(route_invalid));
	ldcfg_host i_ldcfg_host (.sys_clk(sys_clk), .cfg_index(cfg_index), .cfg_wdata(cfg_wdata),
		.cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_ldn(cfg_ldn), .cfg_rdata(cfg_rdata));
	// ==========================================
	// Reference model
	function automatic int exp_rd(int idx);
		if (idx == 'h30) return act;
		if (!act) return 0;
		case (idx)
			'h60: return b0h;
			'h61: return b0l;
			'h70: return irqn;
			'h71: return irqt;
			'h74, 'h75: return 4;
			default: return 0;
		endcase
	endfunction : exp_rd
	task automatic wr_both(int device_selector, int idx, int d);
		i_ldcfg_host.access(8'(device_selector), 8'(idx), 8'(d), 1'b1, rd);
		if (device_selector == 4 && idx == 'h30) act = d & 1;
		else if (device_selector == 4 && act != 0) begin
			case (idx)
				'h60: b0h = d & 'hff;
				'h61: b0l = d & 'he0;
				'h70: irqn = d & 'h1f;
				'h71: irqt = d & 3;
				default: ;
			endcase
		end
	endtask : wr_both
	task automatic check_all();
		int lvl, ok;
		lvl = irqn & 15;
		ok = act && lvl != 0 && lvl != 13;
		for (int s = 0; s < 2; s++) begin
			@(negedge sys_clk) dev_irq = 1'(s);
			repeat (2) @(negedge sys_clk);
			`CHK(dev_active, 1'(act), "active")
			`CHK(io_window_base, 16'((b0h << 8) | b0l), "base")
			`CHK(serirq_levels, 16'(ok ? (s ^ (irqt >> 1)) << lvl : 0), "levels")
			`CHK(wake_event, 1'(act & (irqn >> 4) & s), "wake")
			`CHK(route_invalid, 1'(lvl == 13), "invalid")
		end
		foreach (idxs[k]) begin
			i_ldcfg_host.access(8'h04, 8'(idxs[k]), 8'h00, 1'b0, rd);
			`CHK(rd, 8'(exp_rd(idxs[k])), "read")
		end
		i_ldcfg_host.access(8'h05, 8'h30, 8'h00, 1'b0, rd);
		`CHK(rd, 8'h00, "other device")
	endtask : check_all
	task automatic complete_run();
		$display("mismatches %0d comparisons %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : complete_run
	// ==========================================
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles > 20000) begin
			err_total++;
			complete_run();
		end
	end
	initial begin
		act = 0; b0h = 0; b0l = 0; irqn = 0; irqt = 3;
		repeat (20) @(posedge sys_clk);
		@(negedge sys_clk) rst = 1'b0;
		void'($urandom(32'h4c6fafd8));
		check_all();
		foreach (dir_i[k]) begin
			wr_both(4, dir_i[k], dir_d[k]);
			check_all();
		end
		repeat (250) begin
			wr_both(($urandom % 2) ? 4 : $urandom % 8, idxs[$urandom % 10], $urandom % 256);
			check_all();
		end
		wr_both(4, 'h70, 'h03);
		check_all();
		complete_run();
	end
endmodule : tb
`default_nettype wire
